// [rfsb_regs.svh]
`ifndef RFSB_REGS_SVH
`define RFSB_REGS_SVH
// Behaviour
// - 32 registers visible, 28 general, four reserved
// - Globals persist; locals fresh on every call
// - Call saves caller locals; return restores them
// - Four local frame sets held on chip
// - Load issue sets destination scoreboard bits
// - Load data written clears its scoreboard bit
// - Independent instructions proceed during outstanding loads
// - Dependent instructions stall until load completes
// - Bursts 1,2,4,8,12,16 bytes to consecutive registers

`define RFSB_NREG      32
`define RFSB_NLOC      16
`define RFSB_USABLE    28
`define RFSB_NFRAMES   4
`define RFSB_DEPTH_W   8
`define RFSB_RSV_PFP   5'h00
`define RFSB_RSV_SP    5'h01
`define RFSB_RSV_RIP   5'h02
`define RFSB_RSV_FP    5'h1f
`define RFSB_FRAME_LAST 5'h0f

`endif

// [rfsb_pkg.sv]
package rfsb_pkg;

	typedef enum logic [2:0] {
		RFSB_OP_NOP   = 3'h0,
		RFSB_OP_ALU   = 3'h1,
		RFSB_OP_LOAD  = 3'h2,
		RFSB_OP_STORE = 3'h3,
		RFSB_OP_CALL  = 3'h4,
		RFSB_OP_RET   = 3'h5
	} rfsb_op_t;

	typedef enum logic [2:0] {
		RFSB_SZ_1  = 3'h0,
		RFSB_SZ_2  = 3'h1,
		RFSB_SZ_4  = 3'h2,
		RFSB_SZ_8  = 3'h3,
		RFSB_SZ_12 = 3'h4,
		RFSB_SZ_16 = 3'h5
	} rfsb_size_t;

	typedef enum logic [1:0] {
		RFSB_ST_IDLE  = 2'h0,
		RFSB_ST_STORE = 2'h1,
		RFSB_ST_SPILL = 2'h2,
		RFSB_ST_FILL  = 2'h3
	} rfsb_state_t;

	typedef struct packed {
		logic       valid;
		rfsb_op_t   op;
		rfsb_size_t size;
		logic [4:0] src_a;
		logic [4:0] src_b;
		logic [4:0] dst;
		logic [31:0] wdata;
	} rfsb_iss_t;

	typedef struct packed {
		logic        valid;
		logic [4:0]  idx;
		logic [31:0] data;
	} rfsb_ld_t;

	typedef struct packed {
		logic        valid;
		logic        last;
		logic        spill;
		logic [31:0] data;
	} rfsb_mw_t;

endpackage

// [rfsb_bank.sv]
`timescale 1ns/1ps
`include "rfsb_regs.svh"

module rfsb_bank
	import rfsb_pkg::*;
#(
	parameter int N_FRAMES = `RFSB_NFRAMES,
	parameter int SW       = $clog2(N_FRAMES)
) (
	input  wire logic                 i_sys_clk,
	input  wire logic                 i_rstn,
	input  wire logic                 i_clr,
	input  wire logic [SW-1:0]        i_clr_slot,
	input  wire logic [2:0]           i_wr_en,
	input  wire logic [2:0][SW-1:0]   i_wr_slot,
	input  wire logic [2:0][3:0]      i_wr_idx,
	input  wire logic [2:0][31:0]     i_wr_data,
	input  wire logic [2:0][SW-1:0]   i_rd_slot,
	input  wire logic [2:0][3:0]      i_rd_idx,
	output logic      [2:0][31:0]     o_rd_data
);

	if (N_FRAMES < 2 || (1 << SW) != N_FRAMES) begin : g_chk_sw
		$error("N_FRAMES must be a power of two matching SW");
	end

	typedef struct packed {
		logic [N_FRAMES-1:0][`RFSB_NLOC-1:0][31:0] mem;
	} rfsb_bank_st_t;

	rfsb_bank_st_t q;
	rfsb_bank_st_t d;

	// ****************************************
	// Frame storage, later write ports win
	// ****************************************
	always_comb begin
		d = q;
		if (i_clr) begin
			d.mem[i_clr_slot] = '0;
		end
		for (int w = 0; w < 3; w++) begin
			if (i_wr_en[w]) begin
				d.mem[i_wr_slot[w]][i_wr_idx[w]] = i_wr_data[w];
			end
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	for (genvar r = 0; r < 3; r++) begin : g_rd
		assign o_rd_data[r] = q.mem[i_rd_slot[r]][i_rd_idx[r]];
	end

endmodule

// [rfsb_top.sv]
`timescale 1ns/1ps
`include "rfsb_regs.svh"

module rfsb_top
	import rfsb_pkg::*;
#(
	parameter int N_FRAMES = `RFSB_NFRAMES,
	parameter int DEPTH_W  = `RFSB_DEPTH_W
) (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rstn,
	input  wire rfsb_iss_t   i_iss,
	input  wire rfsb_ld_t    i_ld,
	input  wire logic        i_mw_ready,
	input  wire logic        i_fr_valid,
	input  wire logic [31:0] i_fr_data,
	output logic             o_iss_grant,
	output logic [31:0]      o_rd_a,
	output logic [31:0]      o_rd_b,
	output logic             o_ld_req,
	output logic [4:0]       o_ld_dst,
	output logic [2:0]       o_ld_words,
	output rfsb_mw_t         o_mw,
	output logic             o_fr_req,
	output logic [31:0]      o_sb
);

	localparam int SW = $clog2(N_FRAMES);

	// ****************************************
	// Elaboration checks
	// ****************************************
	if (N_FRAMES < 2 || (1 << SW) != N_FRAMES) begin : g_chk_frames
		$error("N_FRAMES must be a power of two, at least 2");
	end
	if (DEPTH_W < 2 || DEPTH_W > 16) begin : g_chk_depth
		$error("DEPTH_W must lie in 2..16");
	end

	typedef struct packed {
		rfsb_state_t                 st;
		logic [SW-1:0]               cur;
		logic [SW:0]                 res;
		logic [DEPTH_W-1:0]          depth;
		logic [4:0]                  cnt;
		logic [4:0]                  base;
		logic [2:0]                  words;
		logic [`RFSB_NLOC-1:0][31:0] glob;
		logic [31:0]                 sb;
		logic                        grant;
		logic [31:0]                 rd_a;
		logic [31:0]                 rd_b;
		logic                        ld_req;
		logic [4:0]                  ld_dst;
		logic [2:0]                  ld_words;
		rfsb_mw_t                    mw;
		logic                        fr_req;
	} rfsb_top_st_t;

	rfsb_top_st_t q;
	rfsb_top_st_t d;

	logic                 clr;
	logic [SW-1:0]        clr_slot;
	logic [2:0]           wr_en;
	logic [2:0][SW-1:0]   wr_slot;
	logic [2:0][3:0]      wr_idx;
	logic [2:0][31:0]     wr_data;
	logic [2:0][SW-1:0]   rd_slot;
	logic [2:0][3:0]      rd_idx;
	logic [2:0][31:0]     rd_data;

	// ****************************************
	// Decode helpers
	// ****************************************
	function automatic logic [2:0] f_words(input rfsb_size_t sz);
		case (sz)
			RFSB_SZ_8:  f_words = 3'h2;
			RFSB_SZ_12: f_words = 3'h3;
			RFSB_SZ_16: f_words = 3'h4;
			default:    f_words = 3'h1;
		endcase
	endfunction

	// Consecutive register, wrapping inside its local or global group
	function automatic logic [4:0] f_reg(input logic [4:0] base,
	                                     input logic [4:0] i);
		f_reg = {base[4], base[3:0] + i[3:0]};
	endfunction

	function automatic logic f_busy(input logic [31:0] sb,
	                                input logic [4:0]  base,
	                                input logic [2:0]  n);
		f_busy = 1'b0;
		for (int i = 0; i < 4; i++) begin
			if (3'(i) < n && sb[f_reg(base, 5'(i))]) begin
				f_busy = 1'b1;
			end
		end
	endfunction

	function automatic logic f_rsv(input logic [4:0] idx);
		f_rsv = (idx == `RFSB_RSV_PFP) || (idx == `RFSB_RSV_SP) ||
		        (idx == `RFSB_RSV_RIP) || (idx == `RFSB_RSV_FP);
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	logic        hazard;
	logic [2:0]  n_iss;
	logic [4:0]  lim;
	logic [4:0]  sreg;
	logic        mw_acc;
	logic        mw_free;

	always_comb begin
		d = q;
		d.grant  = 1'b0;
		d.ld_req = 1'b0;
		d.fr_req = 1'b0;
		clr      = 1'b0;
		clr_slot = q.cur + SW'(1);
		wr_en    = '0;
		wr_slot  = '0;
		wr_idx   = '0;
		wr_data  = '0;
		n_iss    = f_words(i_iss.size);
		sreg     = f_reg(q.base, q.cnt);
		lim      = (q.st == RFSB_ST_SPILL) ? 5'h10 : {2'h0, q.words};
		mw_acc   = q.mw.valid && i_mw_ready;
		mw_free  = !q.mw.valid || i_mw_ready;

		rd_slot[0] = q.cur;
		rd_slot[1] = q.cur;
		rd_idx[0]  = i_iss.src_a[3:0];
		rd_idx[1]  = i_iss.src_b[3:0];
		rd_slot[2] = (q.st == RFSB_ST_SPILL) ? q.cur + SW'(1) : q.cur;
		rd_idx[2]  = (q.st == RFSB_ST_SPILL) ? q.cnt[3:0] : sreg[3:0];

		case (i_iss.op)
			RFSB_OP_ALU: hazard = q.sb[i_iss.src_a] || q.sb[i_iss.src_b] ||
			                      q.sb[i_iss.dst];
			RFSB_OP_LOAD,
			RFSB_OP_STORE: hazard = q.sb[i_iss.src_a] ||
			                        f_busy(q.sb, i_iss.dst, n_iss);
			RFSB_OP_CALL,
			RFSB_OP_RET: hazard = |q.sb[`RFSB_NLOC-1:0];
			default: hazard = 1'b0;
		endcase

		// Returned load data; clear comes before any set below
		if (i_ld.valid) begin
			d.sb[i_ld.idx] = 1'b0;
			if (i_ld.idx[4]) begin
				d.glob[i_ld.idx[3:0]] = i_ld.data;
			end else begin
				wr_en[0]   = 1'b1;
				wr_slot[0] = q.cur;
				wr_idx[0]  = i_ld.idx[3:0];
				wr_data[0] = i_ld.data;
			end
		end

		case (q.st)
			RFSB_ST_IDLE: begin
				if (i_iss.valid && !q.grant && !hazard) begin
					d.grant = 1'b1;
					d.rd_a  = i_iss.src_a[4] ? q.glob[i_iss.src_a[3:0]]
					                         : rd_data[0];
					d.rd_b  = i_iss.src_b[4] ? q.glob[i_iss.src_b[3:0]]
					                         : rd_data[1];
					case (i_iss.op)
						RFSB_OP_ALU: begin
							if (!f_rsv(i_iss.dst)) begin
								if (i_iss.dst[4]) begin
									d.glob[i_iss.dst[3:0]] = i_iss.wdata;
								end else begin
									wr_en[1]   = 1'b1;
									wr_slot[1] = q.cur;
									wr_idx[1]  = i_iss.dst[3:0];
									wr_data[1] = i_iss.wdata;
								end
							end
						end
						RFSB_OP_LOAD: begin
							for (int i = 0; i < 4; i++) begin
								if (3'(i) < n_iss) begin
									d.sb[f_reg(i_iss.dst, 5'(i))] = 1'b1;
								end
							end
							d.ld_req   = 1'b1;
							d.ld_dst   = i_iss.dst;
							d.ld_words = n_iss;
						end
						RFSB_OP_STORE: begin
							d.grant = 1'b0;
							d.st    = RFSB_ST_STORE;
							d.cnt   = '0;
							d.base  = i_iss.dst;
							d.words = n_iss;
						end
						RFSB_OP_CALL: begin
							if (q.depth != '1) begin
								if (q.res == (SW+1)'(N_FRAMES)) begin
									d.grant = 1'b0;
									d.st    = RFSB_ST_SPILL;
									d.cnt   = '0;
								end else begin
									d.cur   = q.cur + SW'(1);
									d.res   = q.res + (SW+1)'(1);
									d.depth = q.depth + DEPTH_W'(1);
									clr     = 1'b1;
								end
							end
						end
						RFSB_OP_RET: begin
							if (q.depth != '0) begin
								d.cur   = q.cur - SW'(1);
								d.depth = q.depth - DEPTH_W'(1);
								if (q.res > (SW+1)'(1)) begin
									d.res = q.res - (SW+1)'(1);
								end else begin
									d.grant  = 1'b0;
									d.fr_req = 1'b1;
									d.st     = RFSB_ST_FILL;
									d.cnt    = '0;
								end
							end
						end
						default: ;
					endcase
				end
			end
			RFSB_ST_STORE,
			RFSB_ST_SPILL: begin
				if (mw_free && q.cnt < lim) begin
					d.mw.valid = 1'b1;
					d.mw.spill = (q.st == RFSB_ST_SPILL);
					d.mw.last  = (q.cnt == lim - 5'h01);
					d.mw.data  = (q.st == RFSB_ST_STORE && sreg[4])
					             ? q.glob[sreg[3:0]] : rd_data[2];
					d.cnt      = q.cnt + 5'h01;
				end else if (mw_acc) begin
					d.mw.valid = 1'b0;
				end
				if (mw_acc && q.mw.last) begin
					d.st    = RFSB_ST_IDLE;
					d.grant = 1'b1;
					if (q.st == RFSB_ST_SPILL) begin
						d.cur   = q.cur + SW'(1);
						d.depth = q.depth + DEPTH_W'(1);
						clr     = 1'b1;
					end
				end
			end
			RFSB_ST_FILL: begin
				if (i_fr_valid) begin
					wr_en[2]   = 1'b1;
					wr_slot[2] = q.cur;
					wr_idx[2]  = q.cnt[3:0];
					wr_data[2] = i_fr_data;
					d.cnt      = q.cnt + 5'h01;
					if (q.cnt == `RFSB_FRAME_LAST) begin
						d.st    = RFSB_ST_IDLE;
						d.grant = 1'b1;
					end
				end
			end
			default: d.st = RFSB_ST_IDLE;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			q     <= '0;
			q.res <= (SW+1)'(1);
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// Local frame storage
	// ****************************************
	rfsb_bank #(
		.N_FRAMES (N_FRAMES),
		.SW       (SW)
	) u_bank (
		.i_sys_clk  (i_sys_clk),
		.i_rstn     (i_rstn),
		.i_clr      (clr),
		.i_clr_slot (clr_slot),
		.i_wr_en    (wr_en),
		.i_wr_slot  (wr_slot),
		.i_wr_idx   (wr_idx),
		.i_wr_data  (wr_data),
		.i_rd_slot  (rd_slot),
		.i_rd_idx   (rd_idx),
		.o_rd_data  (rd_data)
	);

	assign o_iss_grant = q.grant;
	assign o_rd_a      = q.rd_a;
	assign o_rd_b      = q.rd_b;
	assign o_ld_req    = q.ld_req;
	assign o_ld_dst    = q.ld_dst;
	assign o_ld_words  = q.ld_words;
	assign o_mw        = q.mw;
	assign o_fr_req    = q.fr_req;
	assign o_sb        = q.sb;

endmodule

// [rfsb_checker.sv]
`timescale 1ns/1ps
module rfsb_checker
	import rfsb_pkg::*;
(
	input wire logic        i_sys_clk,
	input wire logic        i_rstn,
	input wire rfsb_iss_t   i_iss,
	input wire rfsb_ld_t    i_ld,
	input wire logic        i_mw_ready,
	input wire logic        o_iss_grant,
	input wire logic        o_ld_req,
	input wire logic [4:0]  o_ld_dst,
	input wire logic [2:0]  o_ld_words,
	input wire rfsb_mw_t    o_mw,
	input wire logic        o_fr_req,
	input wire logic [31:0] o_sb
);
	default clocking @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rstn);
	logic [4:0] spill_q;

	// ****
	// Accepted spill words since the last frame ended
	// ****
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn)
			spill_q <= 5'h00;
		else if (o_mw.valid && o_mw.spill && i_mw_ready)
			spill_q <= o_mw.last ? 5'h00 : spill_q + 5'h01;
	end

	function automatic logic [2:0] nw(input rfsb_size_t s);
		return (s == RFSB_SZ_16) ? 3'h4 : (s == RFSB_SZ_12) ? 3'h3 :
			(s == RFSB_SZ_8) ? 3'h2 : 3'h1;
	endfunction

	property p_ld_set; o_ld_req |-> o_sb[o_ld_dst]; endproperty
	a_ld_set: assert property (p_ld_set)
		else $error("load target not marked");
	property p_ld_op; o_ld_req |-> o_iss_grant &&
		$past(i_iss.op) == RFSB_OP_LOAD && o_ld_dst == $past(i_iss.dst);
	endproperty
	a_ld_op: assert property (p_ld_op)
		else $error("load issue mismatch");
	property p_ld_n; o_ld_req |-> o_ld_words == nw($past(i_iss.size));
	endproperty
	a_ld_n: assert property (p_ld_n)
		else $error("wrong burst word count");
	property p_ld_clr;
		i_ld.valid |=> !o_sb[$past(i_ld.idx)] || o_ld_req;
	endproperty
	a_ld_clr: assert property (p_ld_clr)
		else $error("pending bit not cleared");
	property p_stall; i_iss.valid && i_iss.op == RFSB_OP_ALU &&
		o_sb[i_iss.src_a] |=> !o_iss_grant; endproperty
	a_stall: assert property (p_stall)
		else $error("dependent op not held");
	property p_go; o_iss_grant ##1 (i_iss.valid && i_iss.op == RFSB_OP_ALU
		&& !o_sb[i_iss.src_a] && !o_sb[i_iss.src_b] && !o_sb[i_iss.dst])
		|=> o_iss_grant; endproperty
	a_go: assert property (p_go)
		else $error("independent op held");
	property p_mw_hold; o_mw.valid && !i_mw_ready |=>
		o_mw.valid && $stable(o_mw.data); endproperty
	a_mw_hold: assert property (p_mw_hold)
		else $error("write word dropped");
	property p_spill; o_mw.valid && o_mw.spill && i_mw_ready &&
		o_mw.last |-> spill_q == 5'h0f; endproperty
	a_spill: assert property (p_spill)
		else $error("spill not sixteen words");

	c_load: cover property (o_ld_req);
	c_spill: cover property (o_mw.valid && o_mw.spill && o_mw.last);
	c_fill: cover property (o_fr_req);
	c_store: cover property (o_mw.valid && !o_mw.spill && o_mw.last);
endmodule

bind rfsb_top rfsb_checker u_chk (
	.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_iss(i_iss), .i_ld(i_ld),
	.i_mw_ready(i_mw_ready), .o_iss_grant(o_iss_grant),
	.o_ld_req(o_ld_req), .o_ld_dst(o_ld_dst), .o_ld_words(o_ld_words),
	.o_mw(o_mw), .o_fr_req(o_fr_req), .o_sb(o_sb)
);

// [rfsb_mem_model.sv]
`timescale 1ns/1ps
module rfsb_mem_model
	import rfsb_pkg::*;
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_slow,
	input  wire logic        i_ld_req,
	input  wire logic [4:0]  i_ld_dst,
	input  wire logic [2:0]  i_ld_words,
	input  wire rfsb_mw_t    i_mw,
	input  wire logic        i_fr_req,
	output rfsb_ld_t         o_ld,
	output logic             o_mw_ready,
	output logic             o_fr_valid,
	output logic [31:0]      o_fr_data
);
	logic [4:0]  pend[$];
	logic [31:0] stk[$];
	int          wait_n;
	int          fill_n;

	always @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pend.delete();
			stk.delete();
			wait_n = 0;
			fill_n = 0;
			o_ld <= '0;
			o_mw_ready <= 1'b0;
			o_fr_valid <= 1'b0;
			o_fr_data <= '0;
		end else begin
			// Each word returns once, inside the target group
			if (i_ld_req && pend.size() == 0)
				wait_n = i_slow ? 24 : 1;
			for (int k = 0; k < 4; k++)
				if (i_ld_req && k < i_ld_words)
					pend.push_back({i_ld_dst[4], i_ld_dst[3:0] + 4'(k)});
			o_ld.valid <= 1'b0;
			o_ld.data <= ~o_ld.data;
			if (pend.size() > 0)
				wait_n--;
			if (pend.size() > 0 && wait_n <= 0) begin
				o_ld.valid <= 1'b1;
				o_ld.idx <= pend[0];
				o_ld.data <= 32'h6b000000 | 32'(pend[0]);
				void'(pend.pop_front());
				wait_n = i_slow ? 24 : 1;
			end
			o_mw_ready <= !i_slow || !o_mw_ready;
			if (i_mw.valid && o_mw_ready && i_mw.spill)
				stk.push_back(i_mw.data);
			// Refill returns the newest spilled frame, r0 first
			if (i_fr_req)
				fill_n = 16;
			o_fr_valid <= 1'b0;
			o_fr_data <= ~o_fr_data;
			if (fill_n > 0 && !(i_slow && o_fr_valid)) begin
				o_fr_valid <= 1'b1;
				o_fr_data <= stk[stk.size() - fill_n];
				fill_n--;
				if (fill_n == 0)
					repeat (16) void'(stk.pop_back());
			end
		end
	end
endmodule

// [register_file_with_scoreboard_tb.sv]
`timescale 1ns/1ps
module register_file_with_scoreboard_tb;
	import rfsb_pkg::*;
	logic        clk, rstn, slow, grant, ld_req, mw_ready, fr_valid, fr_req;
	rfsb_iss_t   iss;
	rfsb_ld_t    ld;
	rfsb_mw_t    mw;
	logic [31:0] rd_a, rd_b, fr_data, sb, ra, rb, seed;
	logic [4:0]  ld_dst;
	logic [2:0]  ld_words;
	logic [31:0] rf[32];
	logic [31:0] sv[$];
	logic [31:0] stq[$];
	int          n_fail, checks_done;

	rfsb_top uut (
		.i_sys_clk(clk), .i_rstn(rstn), .i_iss(iss), .i_ld(ld),
		.i_mw_ready(mw_ready), .i_fr_valid(fr_valid), .i_fr_data(fr_data),
		.o_iss_grant(grant), .o_rd_a(rd_a), .o_rd_b(rd_b),
		.o_ld_req(ld_req),
		.o_ld_dst(ld_dst), .o_ld_words(ld_words), .o_mw(mw),
		.o_fr_req(fr_req), .o_sb(sb)
	);
	rfsb_mem_model u_mem (
		.i_sys_clk(clk), .i_rstn(rstn), .i_slow(slow), .i_ld_req(ld_req),
		.i_ld_dst(ld_dst), .i_ld_words(ld_words), .i_mw(mw),
		.i_fr_req(fr_req), .o_ld(ld), .o_mw_ready(mw_ready),
		.o_fr_valid(fr_valid), .o_fr_data(fr_data)
	);

	// ****
	// Helpers
	// ****
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [4:0] grp(input logic [4:0] d, input int k);
		return {d[4], d[3:0] + 4'(k)};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic go(input rfsb_op_t op, input rfsb_size_t sz,
		input logic [4:0] a, input logic [4:0] d, input logic [31:0] wd,
		input logic [4:0] b = 5'h03);
		iss = '{1'b1, op, sz, a, b, d, wd};
		for (int n = 0; n < 500 && grant !== 1'b1; n++) begin
			@(posedge clk);
			#1;
		end
		chk({31'h0, grant}, 32'h1);
		ra = rd_a;
		rb = rd_b;
		@(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [4:0] d, input logic [31:0] v);
		go(RFSB_OP_ALU, RFSB_SZ_4, 5'h03, d, v);
		if (!(d inside {5'h00, 5'h01, 5'h02, 5'h1f}))
			rf[d] = v;
	endtask
	task automatic rdall();
		for (int i = 0; i < 32; i++) begin
			go(RFSB_OP_ALU, RFSB_SZ_4, 5'(i), 5'h00, 32'h0, 5'(31 - i));
			chk(ra, rf[i]);
			chk(rb, rf[31 - i]);
		end
	endtask
	task automatic frame(input logic up);
		go(up ? RFSB_OP_CALL : RFSB_OP_RET, RFSB_SZ_4, 5'h0, 5'h0, 32'h0);
		for (int i = 0; i < 16; i++) begin
			if (up) begin
				sv.push_back(rf[i]);
				rf[i] = 32'h0;
			end else
				rf[15 - i] = sv.pop_back();
		end
	endtask

	always @(posedge clk)
		if (mw.valid === 1'b1 && mw_ready === 1'b1 && mw.spill === 1'b0)
			stq.push_back(mw.data);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#(20 * 40000);
		n_fail++;
		$display("FAIL %0t: watchdog expired", $time);
		stop_test();
	end

	// ****
	// Main sequence
	// ****
	initial begin
		logic [4:0] d;
		int         n;
		iss = '0;
		rstn = 1'b0;
		slow = 1'b0;
		seed = 32'h4ec2ed76;
		n_fail = 0;
		checks_done = 0;
		foreach (rf[i])
			rf[i] = 32'h0;
		repeat (16) @(posedge clk);
		#1;
		rstn = 1'b1;
		for (int i = 0; i < 40; i++)
			wr(5'(rnd()), rnd());
		// Writes to reserved slots must be dropped
		wr(5'h00, rnd());
		wr(5'h1f, rnd());
		rdall();
		for (int p = 0; p < 2; p++) begin
			slow = p[0];
			for (int c = 0; c < 6; c++) begin
				frame(1'b1);
				rdall();
				for (int i = 3; i < 16; i++)
					wr(5'(i), rnd());
				wr(5'(16 + c), rnd());
			end
			for (int c = 0; c < 6; c++) begin
				frame(1'b0);
				rdall();
			end
			// Return at depth zero is granted and changes nothing
			go(RFSB_OP_RET, RFSB_SZ_4, 5'h0, 5'h0, 32'h0);
			rdall();
		end
		for (int k = 0; k < 6; k++) begin
			n = (k < 3) ? 1 : k - 1;
			d = 5'(16 + rnd() % 16);
			slow = 1'b1;
			go(RFSB_OP_LOAD, rfsb_size_t'(k), 5'h03, d, 32'h0);
			chk(32'($countones(sb)), 32'(n));
			wr(5'h03, rnd());
			go(RFSB_OP_NOP, RFSB_SZ_1, 5'h03, 5'h03, 32'h0);
			chk({31'h0, sb != 32'h0}, 32'h1);
			for (int w = 0; w < n; w++)
				rf[grp(d, w)] = 32'h6b000000 | 32'(grp(d, w));
			go(RFSB_OP_ALU, RFSB_SZ_4, grp(d, n - 1), 5'h00, 32'h0);
			chk(ra, rf[grp(d, n - 1)]);
			chk(sb, 32'h0);
			stq.delete();
			go(RFSB_OP_STORE, rfsb_size_t'(k), 5'h03, d, 32'h0);
			chk(32'(stq.size()), 32'(n));
			for (int w = 0; w < n; w++)
				chk(stq[w], rf[grp(d, w)]);
		end
		stop_test();
	end
endmodule
